//--- design/gdr_pkg.sv
// Package with register offsets, field layouts, reset values and timing constants of the delay regulation bank.
package gdr_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] HB3_DELAY_MAX_CURRENT_OFS     = 8'h2d;
  localparam logic [7:0] HB4_DELAY_MAX_CURRENT_OFS     = 8'h2e;
  localparam logic [7:0] HB1_LOOP_INITIAL_SETTINGS_OFS = 8'h2f;
  localparam logic [7:0] HB2_LOOP_INITIAL_SETTINGS_OFS = 8'h30;
  localparam logic [7:0] HB3_LOOP_INITIAL_SETTINGS_OFS = 8'h31;

  localparam logic [7:0] DELAY_MAX_CURRENT_RST     = 8'h0a;
  localparam logic [7:0] LOOP_INITIAL_SETTINGS_RST = 8'hf6;

  localparam int unsigned MAX_CURRENT_MSB  = 7;
  localparam int unsigned MAX_CURRENT_LSB  = 6;
  localparam int unsigned DELAY_TARGET_MSB = 5;
  localparam int unsigned DELAY_TARGET_LSB = 0;
  localparam int unsigned DELAY_CODED_MSB  = 3;

  localparam int unsigned PRECHG_RATIO_MSB    = 7;
  localparam int unsigned PRECHG_RATIO_LSB    = 6;
  localparam int unsigned PREDCHG_RATIO_MSB   = 5;
  localparam int unsigned PREDCHG_RATIO_LSB   = 4;
  localparam int unsigned PRECHG_INIT_MSB     = 3;
  localparam int unsigned PRECHG_INIT_LSB     = 2;
  localparam int unsigned PREDCHG_INIT_MSB    = 1;
  localparam int unsigned PREDCHG_INIT_LSB    = 0;

  // Delay step and its length in clock cycles at 100 MHz.
  localparam int unsigned CLOCK_PERIOD_PS     = 10000;
  localparam int unsigned DELAY_STEP_NS       = 140;
  localparam int unsigned DELAY_STEP_CYCLES   = (DELAY_STEP_NS * 1000) / CLOCK_PERIOD_PS;

  // Current codes in mA.
  localparam logic [6:0] MAX_CURRENT_MA_00 = 7'h40;
  localparam logic [6:0] MAX_CURRENT_MA_01 = 7'h20;
  localparam logic [6:0] MAX_CURRENT_MA_10 = 7'h10;
  localparam logic [6:0] MAX_CURRENT_MA_11 = 7'h08;
  localparam logic [6:0] INIT_CURRENT_MA_00 = 7'h04;
  localparam logic [6:0] INIT_CURRENT_MA_01 = 7'h08;
  localparam logic [6:0] INIT_CURRENT_MA_10 = 7'h10;
  localparam logic [6:0] INIT_CURRENT_MA_11 = 7'h20;

  localparam int unsigned CYCLE_W = 12;

  // Maximum pre-charge and pre-discharge current from its code.
  function automatic logic [6:0] gdr_max_current_ma(input logic [1:0] code);
    case (code)
      2'h0:    gdr_max_current_ma = MAX_CURRENT_MA_00;
      2'h1:    gdr_max_current_ma = MAX_CURRENT_MA_01;
      2'h2:    gdr_max_current_ma = MAX_CURRENT_MA_10;
      default: gdr_max_current_ma = MAX_CURRENT_MA_11;
    endcase
  endfunction

  // Starting loop current from its code.
  function automatic logic [6:0] gdr_init_current_ma(input logic [1:0] code);
    case (code)
      2'h0:    gdr_init_current_ma = INIT_CURRENT_MA_00;
      2'h1:    gdr_init_current_ma = INIT_CURRENT_MA_01;
      2'h2:    gdr_init_current_ma = INIT_CURRENT_MA_10;
      default: gdr_init_current_ma = INIT_CURRENT_MA_11;
    endcase
  endfunction

endpackage

//--- design/gdr_half_bridge_timing.sv
// Per half-bridge timing decoder turning delay and ratio fields into clock cycle counts.
`timescale 1ns/1ps
module gdr_half_bridge_timing
  import gdr_pkg::*;
(
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               sys_rst,
  // Fields
  input  wire logic [5:0]         delay_target,
  input  wire logic [1:0]         precharge_time_ratio,
  input  wire logic [1:0]         predischarge_time_ratio,
  // Decoded times in clock cycles
  output logic      [CYCLE_W-1:0] delay_cycles,
  output logic      [CYCLE_W-1:0] precharge_cycles,
  output logic      [CYCLE_W-1:0] predischarge_cycles
);

  localparam logic [CYCLE_W-1:0] STEP = CYCLE_W'(DELAY_STEP_CYCLES);

  logic [CYCLE_W-1:0] delay_next;
  logic [CYCLE_W-1:0] six_bit_cycles;

  // Ratio of a time in eighths: code 0..3 gives 1/8, 2/8, 3/8, 4/8.
  function automatic logic [CYCLE_W-1:0] ratio_of(input logic [CYCLE_W-1:0] base, input logic [1:0] code);
    logic [CYCLE_W+2:0] prod;
    prod = {3'h0, base} * ({13'h0, code} + 15'h1);
    ratio_of = prod[CYCLE_W+2:3];
  endfunction

  assign delay_next     = STEP * {8'h0, delay_target[DELAY_CODED_MSB:0]};
  assign six_bit_cycles = STEP * {6'h0, delay_target};

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      delay_cycles        <= '0;
      precharge_cycles    <= '0;
      predischarge_cycles <= '0;
    end else begin
      delay_cycles        <= delay_next;
      precharge_cycles    <= ratio_of(six_bit_cycles, precharge_time_ratio);
      predischarge_cycles <= ratio_of(six_bit_cycles, predischarge_time_ratio);
    end
  end

endmodule

//--- design/gdr_delay_regulation_regs.sv
// Register bank holding delay regulation loop targets and initial settings, with decoded outputs.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps

// Overview of operation
// - Bits 7-6 of delay registers pick max pre-charge current 64/32/16/8 mA, reset 00b.
// - Bits 5-0 hold on/off delay target; delay is 140 ns times bits 3-0.
// - Offset 0x2d serves half-bridge 3, 0x2e half-bridge 4; both reset to 0x0a.
// - At 0x31 only, initial bits 7-6 set pre-charge time as 1/8 to 1/2 of delay field.
// - At 0x31 only, initial bits 5-4 set pre-discharge time as 1/8 to 1/2 of delay field.
// - Initial bits 3-2 choose starting pre-charge current 4/8/16/32 mA, reset 01b.
// - Initial bits 1-0 choose starting pre-discharge current 4/8/16/32 mA, reset 10b.
// - Offsets 0x2f, 0x30, 0x31 serve half-bridges 1, 2, 3; each resets to 0xf6.
module gdr_delay_regulation_regs
  import gdr_pkg::*;
(
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               sys_rst,
  // Register port
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [DATA_W-1:0]  reg_rdata,
  // Half-bridge 3 and 4 limits and delay times
  output logic      [6:0]         hb3_max_current_ma,
  output logic      [6:0]         hb4_max_current_ma,
  output logic      [CYCLE_W-1:0] hb3_on_off_delay_cycles,
  output logic      [CYCLE_W-1:0] hb4_on_off_delay_cycles,
  // Half-bridge 3 pre-charge and pre-discharge times
  output logic      [CYCLE_W-1:0] hb3_precharge_cycles,
  output logic      [CYCLE_W-1:0] hb3_predischarge_cycles,
  // Half-bridge 1 to 3 starting loop currents
  output logic      [6:0]         hb1_initial_precharge_current_ma,
  output logic      [6:0]         hb1_initial_predischarge_current_ma,
  output logic      [6:0]         hb2_initial_precharge_current_ma,
  output logic      [6:0]         hb2_initial_predischarge_current_ma,
  output logic      [6:0]         hb3_initial_precharge_current_ma,
  output logic      [6:0]         hb3_initial_predischarge_current_ma
);

  logic [7:0] hb3_delay_max_current_reg;
  logic [7:0] hb4_delay_max_current_reg;
  logic [7:0] hb1_loop_initial_settings_reg;
  logic [7:0] hb2_loop_initial_settings_reg;
  logic [7:0] hb3_loop_initial_settings_reg;
  logic [7:0] reg_rdata_next;
  // Register select decoded from the offset.
  logic [4:0] addr_sel;
  logic [4:0] wr_sel;
  // Fields of the half-bridge 3 and 4 delay and limit registers.
  logic [1:0] hb3_max_current_code;
  logic [1:0] hb4_max_current_code;
  logic [5:0] hb3_on_off_delay_target;
  logic [5:0] hb4_on_off_delay_target;
  // Fields of the initial setting registers.
  logic [1:0] hb3_precharge_time_ratio;
  logic [1:0] hb3_predischarge_time_ratio;
  logic [1:0] hb1_initial_precharge_current_code;
  logic [1:0] hb2_initial_precharge_current_code;
  logic [1:0] hb3_initial_precharge_current_code;
  logic [1:0] hb1_initial_predischarge_current_code;
  logic [1:0] hb2_initial_predischarge_current_code;
  logic [1:0] hb3_initial_predischarge_current_code;

  // One-hot register select for an offset; zero for unmapped offsets.
  function automatic logic [4:0] reg_select(input logic [ADDR_W-1:0] addr);
    case (addr)
      HB3_DELAY_MAX_CURRENT_OFS:     reg_select = 5'h01;
      HB4_DELAY_MAX_CURRENT_OFS:     reg_select = 5'h02;
      HB1_LOOP_INITIAL_SETTINGS_OFS: reg_select = 5'h04;
      HB2_LOOP_INITIAL_SETTINGS_OFS: reg_select = 5'h08;
      HB3_LOOP_INITIAL_SETTINGS_OFS: reg_select = 5'h10;
      default:                       reg_select = 5'h00;
    endcase
  endfunction

  // Write enables, one for each register.
  assign addr_sel = reg_select(reg_addr);
  assign wr_sel   = reg_wr ? addr_sel : 5'h00;

  // Field split of the stored registers.
  assign hb3_max_current_code                  = hb3_delay_max_current_reg[MAX_CURRENT_MSB:MAX_CURRENT_LSB];
  assign hb4_max_current_code                  = hb4_delay_max_current_reg[MAX_CURRENT_MSB:MAX_CURRENT_LSB];
  assign hb3_on_off_delay_target               = hb3_delay_max_current_reg[DELAY_TARGET_MSB:DELAY_TARGET_LSB];
  assign hb4_on_off_delay_target               = hb4_delay_max_current_reg[DELAY_TARGET_MSB:DELAY_TARGET_LSB];
  assign hb3_precharge_time_ratio              = hb3_loop_initial_settings_reg[PRECHG_RATIO_MSB:PRECHG_RATIO_LSB];
  assign hb3_predischarge_time_ratio           = hb3_loop_initial_settings_reg[PREDCHG_RATIO_MSB:PREDCHG_RATIO_LSB];
  assign hb1_initial_precharge_current_code    = hb1_loop_initial_settings_reg[PRECHG_INIT_MSB:PRECHG_INIT_LSB];
  assign hb2_initial_precharge_current_code    = hb2_loop_initial_settings_reg[PRECHG_INIT_MSB:PRECHG_INIT_LSB];
  assign hb3_initial_precharge_current_code    = hb3_loop_initial_settings_reg[PRECHG_INIT_MSB:PRECHG_INIT_LSB];
  assign hb1_initial_predischarge_current_code = hb1_loop_initial_settings_reg[PREDCHG_INIT_MSB:PREDCHG_INIT_LSB];
  assign hb2_initial_predischarge_current_code = hb2_loop_initial_settings_reg[PREDCHG_INIT_MSB:PREDCHG_INIT_LSB];
  assign hb3_initial_predischarge_current_code = hb3_loop_initial_settings_reg[PREDCHG_INIT_MSB:PREDCHG_INIT_LSB];

  // Half-bridge 3 delay and current limit register.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hb3_delay_max_current_reg <= DELAY_MAX_CURRENT_RST;
    end else if (wr_sel[0]) begin
      hb3_delay_max_current_reg <= reg_wdata;
    end
  end

  // Half-bridge 4 delay and current limit register.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hb4_delay_max_current_reg <= DELAY_MAX_CURRENT_RST;
    end else if (wr_sel[1]) begin
      hb4_delay_max_current_reg <= reg_wdata;
    end
  end

  // Half-bridge 1 initial setting register.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hb1_loop_initial_settings_reg <= LOOP_INITIAL_SETTINGS_RST;
    end else if (wr_sel[2]) begin
      hb1_loop_initial_settings_reg <= reg_wdata;
    end
  end

  // Half-bridge 2 initial setting register.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hb2_loop_initial_settings_reg <= LOOP_INITIAL_SETTINGS_RST;
    end else if (wr_sel[3]) begin
      hb2_loop_initial_settings_reg <= reg_wdata;
    end
  end

  // Half-bridge 3 initial setting register.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hb3_loop_initial_settings_reg <= LOOP_INITIAL_SETTINGS_RST;
    end else if (wr_sel[4]) begin
      hb3_loop_initial_settings_reg <= reg_wdata;
    end
  end

  // Read decode; unmapped offsets return zero.
  always_comb begin
    case (reg_addr)
      HB3_DELAY_MAX_CURRENT_OFS:     reg_rdata_next = hb3_delay_max_current_reg;
      HB4_DELAY_MAX_CURRENT_OFS:     reg_rdata_next = hb4_delay_max_current_reg;
      HB1_LOOP_INITIAL_SETTINGS_OFS: reg_rdata_next = hb1_loop_initial_settings_reg;
      HB2_LOOP_INITIAL_SETTINGS_OFS: reg_rdata_next = hb2_loop_initial_settings_reg;
      HB3_LOOP_INITIAL_SETTINGS_OFS: reg_rdata_next = hb3_loop_initial_settings_reg;
      default:                       reg_rdata_next = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= reg_rdata_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Half-bridge 3 maximum pre-charge and pre-discharge current.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hb3_max_current_ma <= MAX_CURRENT_MA_00;
    end else begin
      hb3_max_current_ma <= gdr_max_current_ma(hb3_max_current_code);
    end
  end

  // Half-bridge 4 maximum pre-charge and pre-discharge current.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hb4_max_current_ma <= MAX_CURRENT_MA_00;
    end else begin
      hb4_max_current_ma <= gdr_max_current_ma(hb4_max_current_code);
    end
  end

  // Half-bridge 1 starting pre-charge current.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hb1_initial_precharge_current_ma <= INIT_CURRENT_MA_01;
    end else begin
      hb1_initial_precharge_current_ma <= gdr_init_current_ma(hb1_initial_precharge_current_code);
    end
  end

  // Half-bridge 2 starting pre-charge current.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hb2_initial_precharge_current_ma <= INIT_CURRENT_MA_01;
    end else begin
      hb2_initial_precharge_current_ma <= gdr_init_current_ma(hb2_initial_precharge_current_code);
    end
  end

  // Half-bridge 3 starting pre-charge current.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hb3_initial_precharge_current_ma <= INIT_CURRENT_MA_01;
    end else begin
      hb3_initial_precharge_current_ma <= gdr_init_current_ma(hb3_initial_precharge_current_code);
    end
  end

  // Half-bridge 1 starting pre-discharge current.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hb1_initial_predischarge_current_ma <= INIT_CURRENT_MA_10;
    end else begin
      hb1_initial_predischarge_current_ma <= gdr_init_current_ma(hb1_initial_predischarge_current_code);
    end
  end

  // Half-bridge 2 starting pre-discharge current.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hb2_initial_predischarge_current_ma <= INIT_CURRENT_MA_10;
    end else begin
      hb2_initial_predischarge_current_ma <= gdr_init_current_ma(hb2_initial_predischarge_current_code);
    end
  end

  // Half-bridge 3 starting pre-discharge current.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hb3_initial_predischarge_current_ma <= INIT_CURRENT_MA_10;
    end else begin
      hb3_initial_predischarge_current_ma <= gdr_init_current_ma(hb3_initial_predischarge_current_code);
    end
  end

  // Half-bridge 3 has both its delay and its initial ratios in this bank.
  gdr_half_bridge_timing u_hb3_timing (
    .clock                   (clock),
    .sys_rst                 (sys_rst),
    .delay_target            (hb3_on_off_delay_target),
    .precharge_time_ratio    (hb3_precharge_time_ratio),
    .predischarge_time_ratio (hb3_predischarge_time_ratio),
    .delay_cycles            (hb3_on_off_delay_cycles),
    .precharge_cycles        (hb3_precharge_cycles),
    .predischarge_cycles     (hb3_predischarge_cycles)
  );

  // Half-bridge 4 ratios live outside this bank; only its delay is decoded.
  gdr_half_bridge_timing u_hb4_timing (
    .clock                   (clock),
    .sys_rst                 (sys_rst),
    .delay_target            (hb4_on_off_delay_target),
    .precharge_time_ratio    (2'h3),
    .predischarge_time_ratio (2'h3),
    .delay_cycles            (hb4_on_off_delay_cycles),
    .precharge_cycles        (),
    .predischarge_cycles     ()
  );

endmodule

//--- dv/gdr_regs_assertions.sv
// Checker of readback and decoded outputs of the delay regulation register bank.
`timescale 1ns/1ps
module gdr_regs_checker
  import gdr_pkg::*;
(
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [6:0]  hb3_max_current_ma,
  input wire logic [6:0]  hb4_max_current_ma,
  input wire logic [11:0] hb3_on_off_delay_cycles,
  input wire logic [6:0]  hb1_initial_precharge_current_ma,
  input wire logic [6:0]  hb1_initial_predischarge_current_ma,
  input wire logic [6:0]  hb3_initial_precharge_current_ma
);
  logic [6:0]  max_exp;
  logic [6:0]  ipre_exp;
  logic [6:0]  idis_exp;
  logic [11:0] dly_exp;
  logic        map_hit;
  assign max_exp  = 7'(8'h40 >> reg_wdata[7:6]);
  assign ipre_exp = 7'(8'h04 << reg_wdata[3:2]);
  assign idis_exp = 7'(8'h04 << reg_wdata[1:0]);
  assign dly_exp  = 12'(reg_wdata[3:0]) * 12'd14;
  assign map_hit  = reg_addr >= 8'h2d && reg_addr <= 8'h31;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  AST_RAW: assert property (reg_wr && map_hit ##1 reg_rd && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("read after write did not return written value");
  AST_UNMAPPED: assert property (reg_rd && !map_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_HB3_MAX: assert property (reg_wr && reg_addr == 8'h2d |-> ##2 hb3_max_current_ma == $past(max_exp, 2))
    else $error("hb3 max current wrong");
  AST_HB4_MAX: assert property (reg_wr && reg_addr == 8'h2e |-> ##2 hb4_max_current_ma == $past(max_exp, 2))
    else $error("hb4 max current wrong");
  AST_HB3_DELAY: assert property (reg_wr && reg_addr == 8'h2d ##1 !reg_wr [*2] |=> hb3_on_off_delay_cycles == $past(dly_exp, 3))
    else $error("hb3 delay cycles wrong");
  AST_HB1_INIT: assert property (reg_wr && reg_addr == 8'h2f |-> ##2 hb1_initial_precharge_current_ma == $past(ipre_exp, 2) && hb1_initial_predischarge_current_ma == $past(idis_exp, 2))
    else $error("hb1 initial currents wrong");
  AST_HB3_INIT: assert property (reg_wr && reg_addr == 8'h31 |-> ##2 hb3_initial_precharge_current_ma == $past(ipre_exp, 2))
    else $error("hb3 initial precharge current wrong");
endmodule
bind gdr_delay_regulation_regs gdr_regs_checker u_chk (
  .clock                               (clock),
  .sys_rst                             (sys_rst),
  .reg_addr                            (reg_addr),
  .reg_wdata                           (reg_wdata),
  .reg_wr                              (reg_wr),
  .reg_rd                              (reg_rd),
  .reg_rdata                           (reg_rdata),
  .hb3_max_current_ma                  (hb3_max_current_ma),
  .hb4_max_current_ma                  (hb4_max_current_ma),
  .hb3_on_off_delay_cycles             (hb3_on_off_delay_cycles),
  .hb1_initial_precharge_current_ma    (hb1_initial_precharge_current_ma),
  .hb1_initial_predischarge_current_ma (hb1_initial_predischarge_current_ma),
  .hb3_initial_precharge_current_ma    (hb3_initial_precharge_current_ma)
);

//--- dv/gate_delay_regulation_config_test.sv
// Self-checking testbench of the delay regulation register bank.
`timescale 1ns/1ps
module gate_delay_regulation_config_test
  import gdr_pkg::*;
;
  logic        clock, sys_rst, reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, last, v;
  logic [6:0]  hb3_max_current_ma, hb4_max_current_ma;
  logic [11:0] hb3_on_off_delay_cycles, hb4_on_off_delay_cycles, hb3_precharge_cycles, hb3_predischarge_cycles;
  logic [6:0]  hb1_initial_precharge_current_ma, hb1_initial_predischarge_current_ma;
  logic [6:0]  hb2_initial_precharge_current_ma, hb2_initial_predischarge_current_ma;
  logic [6:0]  hb3_initial_precharge_current_ma, hb3_initial_predischarge_current_ma;
  logic [7:0]  sh [5];
  logic [7:0]  ofs [5] = '{8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31};
  logic [7:0]  bad [4] = '{8'h2c, 8'h32, 8'h00, 8'hff};
  int          failures, tests_run, k;
  gdr_delay_regulation_regs DUT (
    .clock                               (clock),
    .sys_rst                             (sys_rst),
    .reg_addr                            (reg_addr),
    .reg_wdata                           (reg_wdata),
    .reg_wr                              (reg_wr),
    .reg_rd                              (reg_rd),
    .reg_rdata                           (reg_rdata),
    .hb3_max_current_ma                  (hb3_max_current_ma),
    .hb4_max_current_ma                  (hb4_max_current_ma),
    .hb3_on_off_delay_cycles             (hb3_on_off_delay_cycles),
    .hb4_on_off_delay_cycles             (hb4_on_off_delay_cycles),
    .hb3_precharge_cycles                (hb3_precharge_cycles),
    .hb3_predischarge_cycles             (hb3_predischarge_cycles),
    .hb1_initial_precharge_current_ma    (hb1_initial_precharge_current_ma),
    .hb1_initial_predischarge_current_ma (hb1_initial_predischarge_current_ma),
    .hb2_initial_precharge_current_ma    (hb2_initial_precharge_current_ma),
    .hb2_initial_predischarge_current_ma (hb2_initial_predischarge_current_ma),
    .hb3_initial_precharge_current_ma    (hb3_initial_precharge_current_ma),
    .hb3_initial_predischarge_current_ma (hb3_initial_predischarge_current_ma)
  );
  function automatic logic [6:0] emax(logic [1:0] c);
    return 7'(8'h40 >> c);
  endfunction
  function automatic logic [6:0] einit(logic [1:0] c);
    return 7'(8'h04 << c);
  endfunction
  function automatic logic [11:0] eratio(logic [7:0] d, logic [1:0] c);
    return 12'((14 * d[5:0] * (c + 1)) / 8);
  endfunction
  task automatic check(input logic [11:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic w, r, input logic [7:0] a, d);
    @(posedge clock);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    #1 last = reg_rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, exp);
    op(0, 1, a, 8'h00);
    op(0, 0, a, 8'h00);
    check(last, exp);
  endtask
  task automatic check_all;
    repeat (4) op(0, 0, 8'h00, 8'h00);
    check(hb3_max_current_ma, emax(sh[0][7:6]));
    check(hb4_max_current_ma, emax(sh[1][7:6]));
    check(hb3_on_off_delay_cycles, 12'(14 * sh[0][3:0]));
    check(hb4_on_off_delay_cycles, 12'(14 * sh[1][3:0]));
    check(hb3_precharge_cycles, eratio(sh[0], sh[4][7:6]));
    check(hb3_predischarge_cycles, eratio(sh[0], sh[4][5:4]));
    check(hb1_initial_precharge_current_ma, einit(sh[2][3:2]));
    check(hb2_initial_precharge_current_ma, einit(sh[3][3:2]));
    check(hb3_initial_precharge_current_ma, einit(sh[4][3:2]));
    check(hb1_initial_predischarge_current_ma, einit(sh[2][1:0]));
    check(hb2_initial_predischarge_current_ma, einit(sh[3][1:0]));
    check(hb3_initial_predischarge_current_ma, einit(sh[4][1:0]));
    for (int i = 0; i < 5; i++) begin
      rdchk(ofs[i], sh[i]);
    end
  endtask
  task automatic do_reset;
    @(posedge clock);
    sys_rst <= 1'b1;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    sh = '{8'h0a, 8'h0a, 8'hf6, 8'hf6, 8'hf6};
  endtask
  task automatic wrap_up;
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #100us;
    failures++;
    wrap_up;
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 16'h0000};
    failures = 0;
    tests_run = 0;
    void'($urandom(32'h7eb8));
    do_reset;
    check_all;
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 5; i++) begin
        sh[i] = {4{2'(c)}};
        op(1, 0, ofs[i], sh[i]);
      end
      check_all;
    end
    repeat (40) begin
      k = $urandom_range(4);
      v = 8'($urandom);
      sh[k] = v;
      op(1, 0, ofs[k], v);
      rdchk(ofs[k], v);
    end
    check_all;
    foreach (bad[j]) begin
      op(1, 0, bad[j], 8'h00);
      rdchk(bad[j], 8'h00);
    end
    check_all;
    op(1, 0, 8'h2d, 8'hff);
    do_reset;
    check_all;
    wrap_up;
  end
endmodule
